// file: rtl/sdrwb_top.sv
// write burst sequencer: register port, config crossing, link capture
//
// Overview of operation
// - burst field 0:0 makes every access an eight_beat_burst.
// - field 0:1 samples burst_chop_select_bit per write; high means eight beats.
// - field 0:1 with the select bit low chops that write to four beats.
// - reads apply the same per-command selection independently of writes.
// - field 1:0 makes every access a chopped_four_beat_burst, bit ignored.
// - recovery and write-to-read counts start at edge after last beat.
// - with data_bus_inversion on, its own recovery and read delays apply.
module sdrwb_top #(
	parameter int PIPE_D = 32,
	parameter int DW = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic link_clk,
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic cmd_pre,
	input wire logic [1:0] cmd_group,
	input wire logic [1:0] cmd_bank,
	input wire logic burst_chop_select_bit,
	input wire logic [DW-1:0] wdata_rise,
	input wire logic [DW-1:0] wdata_fall,
	output logic beat_valid,
	output logic [2*DW-1:0] beat_data,
	output logic beat_last,
	output logic rd_start,
	output logic rd_chop
);
	// ------------------------------------------------------------
	// core domain: working registers
	// ------------------------------------------------------------
	logic [1:0] mode_q;
	logic pre2_q, dbi_q;
	logic [4:0] cwl_q, al_q, cwl_min_q;
	logic [5:0] twr_q, twtrl_q, twtrs_q, twrd_q, twtrld_q, twtrsd_q;
	logic dirty_q, req_q, ack_meta_q, ack_q;
	logic req_seen_l_q; // link side, read back through two flops
	logic [49:0] snap_q;
	logic [31:0] rdata_q;
	logic rd_early_q, pre_early_q;
	logic [7:0] wr_cnt_q;
	logic cfg_bad;
	logic [sdrwb_pkg::N_EVT-1:0] evt_tgl_l_q, evt_pulse;
	logic wsel;

	assign wsel = reg_wr;

	// register writes; any write marks the config for transfer
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			mode_q <= sdrwb_pkg::BL_FIXED8;
			pre2_q <= 1'b0;
			dbi_q <= 1'b0;
			cwl_q <= sdrwb_pkg::RST_CWL;
			cwl_min_q <= sdrwb_pkg::RST_CWL_MIN;
			al_q <= sdrwb_pkg::RST_AL;
			twr_q <= sdrwb_pkg::RST_TWR;
			twtrl_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_L;
			twtrs_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_S;
			twrd_q <= sdrwb_pkg::RST_TWR_DBI;
			twtrld_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_L_DBI;
			twtrsd_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_S_DBI;
		end else if (wsel) begin
			case (reg_addr)
				sdrwb_pkg::OFS_CTRL: begin
					mode_q <= reg_wdata[sdrwb_pkg::CTRL_MODE_LSB +: 2];
					pre2_q <= reg_wdata[sdrwb_pkg::CTRL_PRE2];
					dbi_q <= reg_wdata[sdrwb_pkg::CTRL_DBI];
				end
				sdrwb_pkg::OFS_CWL: cwl_q <= reg_wdata[4:0];
				sdrwb_pkg::OFS_CWL_MIN: cwl_min_q <= reg_wdata[4:0];
				sdrwb_pkg::OFS_AL: al_q <= reg_wdata[4:0];
				sdrwb_pkg::OFS_TWR: twr_q <= reg_wdata[5:0];
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_L: twtrl_q <= reg_wdata[5:0];
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_S: twtrs_q <= reg_wdata[5:0];
				sdrwb_pkg::OFS_TWR_DBI: twrd_q <= reg_wdata[5:0];
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_L_DBI: twtrld_q <= reg_wdata[5:0];
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_S_DBI: twtrsd_q <= reg_wdata[5:0];
				default: ;
			endcase
		end
	end

	// illegal latency for the two-clock preamble
	assign cfg_bad = pre2_q && (cwl_q < cwl_min_q + sdrwb_pkg::CWL_STEP);

	// ------------------------------------------------------------
	// config snapshot handed to the link by toggle handshake
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dirty_q <= 1'b0;
			req_q <= 1'b0;
			snap_q <= '0;
			ack_meta_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			ack_meta_q <= req_seen_l_q;
			ack_q <= ack_meta_q;
			if (req_q == ack_q && dirty_q) begin
				snap_q <= {mode_q, pre2_q, dbi_q, cwl_q, al_q, twr_q, twtrl_q,
					twtrs_q, twrd_q, twtrld_q, twtrsd_q};
				req_q <= ~req_q;
				dirty_q <= wsel;
			end else if (wsel) begin
				dirty_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// link events into the core domain
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < sdrwb_pkg::N_EVT; gi++) begin : g_evt
			logic meta_q, sync_q, old_q;
			// two flops, then edge detect on the second
			always_ff @(posedge core_clk) begin
				if (!rstn) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					old_q <= 1'b0;
				end else begin
					meta_q <= evt_tgl_l_q[gi];
					sync_q <= meta_q;
					old_q <= sync_q;
				end
			end
			assign evt_pulse[gi] = sync_q ^ old_q;
		end
	endgenerate

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rd_early_q <= 1'b0;
			pre_early_q <= 1'b0;
			wr_cnt_q <= 8'h00;
		end else begin
			if (evt_pulse[sdrwb_pkg::EVT_RD_EARLY]) begin
				rd_early_q <= 1'b1;
			end else if (wsel && reg_addr == sdrwb_pkg::OFS_STATUS &&
				reg_wdata[sdrwb_pkg::ST_RD_EARLY]) begin
				rd_early_q <= 1'b0;
			end
			if (evt_pulse[sdrwb_pkg::EVT_PRE_EARLY]) begin
				pre_early_q <= 1'b1;
			end else if (wsel && reg_addr == sdrwb_pkg::OFS_STATUS &&
				reg_wdata[sdrwb_pkg::ST_PRE_EARLY]) begin
				pre_early_q <= 1'b0;
			end
			if (evt_pulse[sdrwb_pkg::EVT_WR]) begin
				wr_cnt_q <= wr_cnt_q + 8'h01;
			end
		end
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= '0;
			case (reg_addr)
				sdrwb_pkg::OFS_CTRL: begin
					rdata_q[sdrwb_pkg::CTRL_MODE_LSB +: 2] <= mode_q;
					rdata_q[sdrwb_pkg::CTRL_PRE2] <= pre2_q;
					rdata_q[sdrwb_pkg::CTRL_DBI] <= dbi_q;
				end
				sdrwb_pkg::OFS_CWL: rdata_q[4:0] <= cwl_q;
				sdrwb_pkg::OFS_CWL_MIN: rdata_q[4:0] <= cwl_min_q;
				sdrwb_pkg::OFS_AL: rdata_q[4:0] <= al_q;
				sdrwb_pkg::OFS_TWR: rdata_q[5:0] <= twr_q;
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_L: rdata_q[5:0] <= twtrl_q;
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_S: rdata_q[5:0] <= twtrs_q;
				sdrwb_pkg::OFS_TWR_DBI: rdata_q[5:0] <= twrd_q;
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_L_DBI: rdata_q[5:0] <= twtrld_q;
				sdrwb_pkg::OFS_WRITE_TO_READ_DELAY_S_DBI: rdata_q[5:0] <= twtrsd_q;
				sdrwb_pkg::OFS_STATUS: begin
					rdata_q[sdrwb_pkg::ST_RD_EARLY] <= rd_early_q;
					rdata_q[sdrwb_pkg::ST_PRE_EARLY] <= pre_early_q;
					rdata_q[sdrwb_pkg::ST_CFG_BAD] <= cfg_bad;
					rdata_q[sdrwb_pkg::ST_BUSY] <= dirty_q | (req_q ^ ack_q);
					rdata_q[sdrwb_pkg::ST_CNT_LSB +: 8] <= wr_cnt_q;
				end
				default: ;
			endcase
		end
	end
	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// link domain: reset and config capture
	// ------------------------------------------------------------
	logic lrst_meta_q, lrst_q;
	logic req_meta_l_q, req_sync_l_q;
	logic [1:0] mode_l_q;
	logic dbi_l_q;
	logic [4:0] cwl_l_q, al_l_q;
	logic [5:0] twr_l_q, wtrl_l_q, wtrs_l_q, wrd_l_q, wtrld_l_q, wtrsd_l_q;

	// reset release follows the link clock
	always_ff @(posedge link_clk) begin
		lrst_meta_q <= rstn;
		lrst_q <= lrst_meta_q;
	end

	// load the snapshot when a new request toggle arrives
	always_ff @(posedge link_clk) begin
		if (!lrst_q) begin
			req_meta_l_q <= 1'b0;
			req_sync_l_q <= 1'b0;
			req_seen_l_q <= 1'b0;
			mode_l_q <= sdrwb_pkg::BL_FIXED8;
			dbi_l_q <= 1'b0;
			cwl_l_q <= sdrwb_pkg::RST_CWL;
			al_l_q <= sdrwb_pkg::RST_AL;
			twr_l_q <= sdrwb_pkg::RST_TWR;
			wtrl_l_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_L;
			wtrs_l_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_S;
			wrd_l_q <= sdrwb_pkg::RST_TWR_DBI;
			wtrld_l_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_L_DBI;
			wtrsd_l_q <= sdrwb_pkg::RST_WRITE_TO_READ_DELAY_S_DBI;
		end else begin
			req_meta_l_q <= req_q;
			req_sync_l_q <= req_meta_l_q;
			if (req_sync_l_q != req_seen_l_q) begin
				req_seen_l_q <= req_sync_l_q;
				{mode_l_q, dbi_l_q} <= {snap_q[49:48], snap_q[46]};
				{cwl_l_q, al_l_q} <= snap_q[45:36];
				{twr_l_q, wtrl_l_q, wtrs_l_q} <= snap_q[35:18];
				{wrd_l_q, wtrld_l_q, wtrsd_l_q} <= snap_q[17:0];
			end
		end
	end

	// ------------------------------------------------------------
	// burst length per command
	// ------------------------------------------------------------
	logic cmd_chop;
	always_comb begin
		case (mode_l_q)
			sdrwb_pkg::BL_FIXED8: cmd_chop = 1'b0;
			sdrwb_pkg::BL_OTF: cmd_chop = !burst_chop_select_bit;
			sdrwb_pkg::BL_FIXED4: cmd_chop = 1'b1;
			default: cmd_chop = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// write latency pipeline
	// ------------------------------------------------------------
	logic [PIPE_D-1:0] pv_q, pc_q, po_q;
	logic [3:0] pb_q [PIPE_D];
	logic [5:0] wl;
	logic [4:0] tap;
	logic tap_v;

	assign wl = {1'b0, al_l_q} + {1'b0, cwl_l_q};
	assign tap = 5'(wl - 6'h01);
	assign tap_v = pv_q[tap];

	// stage zero takes the command, the rest shift by one clock
	generate
		for (gi = 0; gi < PIPE_D; gi++) begin : g_pipe
			if (gi == 0) begin : g_head
				always_ff @(posedge link_clk) begin
					if (!lrst_q) begin
						pv_q[gi] <= 1'b0;
						pc_q[gi] <= 1'b0;
						po_q[gi] <= 1'b0;
						pb_q[gi] <= 4'h0;
					end else begin
						pv_q[gi] <= cmd_write;
						pc_q[gi] <= cmd_chop;
						po_q[gi] <= (mode_l_q == sdrwb_pkg::BL_OTF);
						pb_q[gi] <= {cmd_group, cmd_bank};
					end
				end
			end else begin : g_tail
				always_ff @(posedge link_clk) begin
					if (!lrst_q) begin
						pv_q[gi] <= 1'b0;
						pc_q[gi] <= 1'b0;
						po_q[gi] <= 1'b0;
						pb_q[gi] <= 4'h0;
					end else begin
						pv_q[gi] <= pv_q[gi-1];
						pc_q[gi] <= pc_q[gi-1];
						po_q[gi] <= po_q[gi-1];
						pb_q[gi] <= pb_q[gi-1];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// data capture, two beats per link clock
	// ------------------------------------------------------------
	sdrwb_pkg::sdrwb_cap_e cap_q;
	logic [2:0] left_q;
	logic [3:0] cur_bk_q;
	logic cur_pad_q, beat_valid_q, beat_last_q;
	logic [2*DW-1:0] beat_data_q;

	always_ff @(posedge link_clk) begin
		if (!lrst_q) begin
			cap_q <= sdrwb_pkg::CAP_IDLE;
			left_q <= 3'h0;
			cur_bk_q <= 4'h0;
			cur_pad_q <= 1'b0;
			beat_valid_q <= 1'b0;
			beat_last_q <= 1'b0;
			beat_data_q <= '0;
		end else begin
			beat_data_q <= {wdata_fall, wdata_rise};
			if (tap_v) begin
				// a new burst may start on the edge the last one ends
				cap_q <= sdrwb_pkg::CAP_BURST;
				left_q <= (pc_q[tap] ? sdrwb_pkg::CLK_BURST4 :
					sdrwb_pkg::CLK_BURST8) - 3'h1;
				cur_bk_q <= pb_q[tap];
				cur_pad_q <= pc_q[tap] & po_q[tap];
				beat_valid_q <= 1'b1;
				beat_last_q <= 1'b0;
			end else begin
				case (cap_q)
					sdrwb_pkg::CAP_BURST: begin
						left_q <= left_q - 3'h1;
						beat_valid_q <= 1'b1;
						beat_last_q <= (left_q == 3'h1);
						if (left_q == 3'h1) begin
							cap_q <= sdrwb_pkg::CAP_IDLE;
						end
					end
					default: begin
						beat_valid_q <= 1'b0;
						beat_last_q <= 1'b0;
					end
				endcase
			end
		end
	end
	assign beat_valid = beat_valid_q;
	assign beat_data = beat_data_q;
	assign beat_last = beat_last_q;

	// ------------------------------------------------------------
	// recovery and write-to-read timers
	// ------------------------------------------------------------
	logic [5:0] wr_t_q, wtrl_t_q, wtrs_t_q, pad;
	logic [3:0] rec_bk_q;
	logic same_grp, rd_bad, pre_bad;

	assign pad = cur_pad_q ? sdrwb_pkg::WBL_PAD : 6'h00;

	// load on the first edge after the final beat
	always_ff @(posedge link_clk) begin
		if (!lrst_q) begin
			wr_t_q <= 6'h00;
			wtrl_t_q <= 6'h00;
			wtrs_t_q <= 6'h00;
			rec_bk_q <= 4'h0;
		end else if (beat_last_q) begin
			wr_t_q <= (dbi_l_q ? wrd_l_q : twr_l_q) - 6'h01;
			wtrl_t_q <= (dbi_l_q ? wtrld_l_q : wtrl_l_q) + pad - 6'h01;
			wtrs_t_q <= (dbi_l_q ? wtrsd_l_q : wtrs_l_q) + pad - 6'h01;
			rec_bk_q <= cur_bk_q;
		end else begin
			if (wr_t_q != 6'h00) wr_t_q <= wr_t_q - 6'h01;
			if (wtrl_t_q != 6'h00) wtrl_t_q <= wtrl_t_q - 6'h01;
			if (wtrs_t_q != 6'h00) wtrs_t_q <= wtrs_t_q - 6'h01;
		end
	end

	// reads run additive_latency later inside, so the margin shrinks
	assign same_grp = (cmd_group == rec_bk_q[3:2]);
	assign rd_bad = cmd_read && (cap_q == sdrwb_pkg::CAP_BURST || beat_last_q ||
		({1'b0, al_l_q} < (same_grp ? wtrl_t_q : wtrs_t_q)));
	assign pre_bad = cmd_pre && ({cmd_group, cmd_bank} == rec_bk_q) &&
		(wr_t_q != 6'h00 || beat_last_q);

	// ------------------------------------------------------------
	// read start marker and event toggles
	// ------------------------------------------------------------
	logic rd_start_q, rd_chop_q;
	always_ff @(posedge link_clk) begin
		if (!lrst_q) begin
			rd_start_q <= 1'b0;
			rd_chop_q <= 1'b0;
			evt_tgl_l_q <= '0;
		end else begin
			rd_start_q <= cmd_read;
			if (cmd_read) rd_chop_q <= cmd_chop;
			evt_tgl_l_q[sdrwb_pkg::EVT_WR] <=
				evt_tgl_l_q[sdrwb_pkg::EVT_WR] ^ beat_last_q;
			evt_tgl_l_q[sdrwb_pkg::EVT_RD_EARLY] <=
				evt_tgl_l_q[sdrwb_pkg::EVT_RD_EARLY] ^ rd_bad;
			evt_tgl_l_q[sdrwb_pkg::EVT_PRE_EARLY] <=
				evt_tgl_l_q[sdrwb_pkg::EVT_PRE_EARLY] ^ pre_bad;
		end
	end
	assign rd_start = rd_start_q;
	assign rd_chop = rd_chop_q;
endmodule // sdrwb_top

// file: rtl/sdrwb_pkg.sv
// constants for the write burst sequencer: register map, fields, resets
package sdrwb_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CWL = 8'h04;
	localparam logic [7:0] OFS_AL = 8'h08;
	localparam logic [7:0] OFS_TWR = 8'h0c;
	localparam logic [7:0] OFS_WRITE_TO_READ_DELAY_L = 8'h10;
	localparam logic [7:0] OFS_WRITE_TO_READ_DELAY_S = 8'h14;
	localparam logic [7:0] OFS_TWR_DBI = 8'h18;
	localparam logic [7:0] OFS_WRITE_TO_READ_DELAY_L_DBI = 8'h1c;
	localparam logic [7:0] OFS_WRITE_TO_READ_DELAY_S_DBI = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_CWL_MIN = 8'h28;
	// ------------------------------------------------------------
	// control and status fields
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PRE2 = 2;
	localparam int CTRL_DBI = 3;
	localparam int ST_RD_EARLY = 0;
	localparam int ST_PRE_EARLY = 1;
	localparam int ST_CFG_BAD = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_CNT_LSB = 8;
	// ------------------------------------------------------------
	// burst length field of mode_register_zero
	// ------------------------------------------------------------
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	// ------------------------------------------------------------
	// reset values and burst shape
	// ------------------------------------------------------------
	localparam logic [4:0] RST_CWL = 5'h09;
	localparam logic [4:0] RST_CWL_MIN = 5'h09;
	localparam logic [4:0] RST_AL = 5'h00;
	localparam logic [5:0] RST_TWR = 6'h0c;
	localparam logic [5:0] RST_WRITE_TO_READ_DELAY_L = 6'h06;
	localparam logic [5:0] RST_WRITE_TO_READ_DELAY_S = 6'h02;
	localparam logic [5:0] RST_TWR_DBI = 6'h0e;
	localparam logic [5:0] RST_WRITE_TO_READ_DELAY_L_DBI = 6'h08;
	localparam logic [5:0] RST_WRITE_TO_READ_DELAY_S_DBI = 6'h04;
	localparam logic [2:0] CLK_BURST8 = 3'h4;
	localparam logic [2:0] CLK_BURST4 = 3'h2;
	localparam logic [5:0] WBL_PAD = 6'h02;
	localparam logic [4:0] CWL_STEP = 5'h01;
	localparam int N_EVT = 3;
	localparam int EVT_WR = 0;
	localparam int EVT_RD_EARLY = 1;
	localparam int EVT_PRE_EARLY = 2;
	typedef enum logic {CAP_IDLE, CAP_BURST} sdrwb_cap_e;
endpackage

// file: verif/sdrwb_top_props.sv
// port assertions for the write burst sequencer
module sdrwb_top_props #(
	parameter int PIPE_D = 32,
	parameter int DW = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic link_clk,
	input wire logic cmd_read,
	input wire logic [DW-1:0] wdata_rise,
	input wire logic [DW-1:0] wdata_fall,
	input wire logic beat_valid,
	input wire logic [2*DW-1:0] beat_data,
	input wire logic beat_last,
	input wire logic rd_start
);
	// link side: read start, burst shape, captured data
	rd_follow_a: assert property (@(posedge link_clk) disable iff (!rstn)
		cmd_read |=> rd_start) else $error("read start missing");
	rd_cause_a: assert property (@(posedge link_clk) disable iff (!rstn)
		rd_start |-> $past(cmd_read)) else $error("read start without read");
	burst_len_a: assert property (@(posedge link_clk) disable iff (!rstn)
		$rose(beat_valid) |-> (##1 beat_last) or (!beat_last ##3 beat_last))
		else $error("burst is neither two nor four pairs");
	burst_run_a: assert property (@(posedge link_clk) disable iff (!rstn)
		beat_valid && !beat_last |=> beat_valid) else $error("burst broken");
	last_valid_a: assert property (@(posedge link_clk) disable iff (!rstn)
		beat_last |-> beat_valid) else $error("last beat outside burst");
	beat_data_a: assert property (@(posedge link_clk) disable iff (!rstn)
		beat_valid |-> beat_data == $past({wdata_fall, wdata_rise}))
		else $error("captured pair differs from link data");
	// register side: read data hold and unmapped reads
	rdata_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
	unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd && reg_addr > 8'h28 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // sdrwb_top_props

bind sdrwb_top sdrwb_top_props #(.PIPE_D(PIPE_D), .DW(DW)) u_props (
	.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .link_clk(link_clk), .cmd_read(cmd_read),
	.wdata_rise(wdata_rise), .wdata_fall(wdata_fall), .beat_valid(beat_valid),
	.beat_data(beat_data), .beat_last(beat_last), .rd_start(rd_start));

// file: verif/sdrwb_ctrl_model.sv
// memory controller model: link commands and write data
module sdrwb_ctrl_model #(
	parameter int DW = 8
) (
	input wire logic link_clk,
	output logic cmd_write,
	output logic cmd_read,
	output logic cmd_pre,
	output logic [1:0] cmd_group,
	output logic [1:0] cmd_bank,
	output logic burst_chop_select_bit,
	output logic [DW-1:0] wdata_rise,
	output logic [DW-1:0] wdata_fall
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	// quiet lines at time zero
	initial begin
		{cmd_write, cmd_read, cmd_pre} = 3'h0;
		{cmd_group, cmd_bank, burst_chop_select_bit} = 5'h0;
		wdata_rise = {DW{1'b0}};
		wdata_fall = {DW{1'b1}};
	end
	// idle lines flip so stale values never pass for valid
	always @(negedge link_clk) begin
		if (!busy) begin
			{cmd_group, cmd_bank} <= ~{cmd_group, cmd_bank};
			burst_chop_select_bit <= ~burst_chop_select_bit;
			wdata_rise <= ~wdata_rise;
			wdata_fall <= ~wdata_fall;
		end
	end
	// one command: caller stands just after a link edge
	task automatic issue(input int kind, input logic [1:0] g, b, input logic a);
		busy = 1'b1;
		{cmd_group, cmd_bank, burst_chop_select_bit} <= {g, b, a};
		{cmd_write, cmd_read, cmd_pre} <= {kind == 0, kind == 1, kind == 2};
		@(posedge link_clk);
		{cmd_write, cmd_read, cmd_pre} <= 3'h0;
		busy = 1'b0;
	endtask
	// write command, then np pairs from write latency on
	task automatic write(input logic [1:0] g, b, input logic a, input int np, wl,
		input logic [7:0] base);
		issue(0, g, b, a);
		repeat (wl - 1) @(posedge link_clk);
		busy = 1'b1;
		for (int k = 0; k < np; k++) begin
			wdata_rise <= DW'(base + 2 * k);
			wdata_fall <= DW'(base + 2 * k + 1);
			@(posedge link_clk);
		end
		busy = 1'b0;
	endtask
endmodule // sdrwb_ctrl_model

// file: verif/sdrwb_top_test.sv
// self-checking bench for the write burst sequencer
module sdrwb_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic cmd_write, cmd_read, cmd_pre, burst_chop_select_bit;
	logic [1:0] cmd_group, cmd_bank;
	logic [7:0] wdata_rise, wdata_fall;
	logic beat_valid, beat_last, rd_start, rd_chop;
	logic [15:0] beat_data;
	int n_mismatch = 0;
	int tests_run = 0;
	// mode, write select, pairs, read select, read chop, additive latency
	int tbl [5][6] = '{'{0, 0, 4, 0, 0, 0}, '{1, 1, 4, 0, 1, 0},
		'{1, 0, 2, 1, 0, 0}, '{2, 1, 2, 1, 1, 0}, '{3, 0, 4, 1, 0, 2}};
	int raw_t [3][3] = '{'{0, 0, 1}, '{0, 30, 0}, '{8, 0, 0}};
	logic [7:0] ofs_t [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
	logic [31:0] rst_t [11] = '{32'h0, 32'h9, 32'h0, 32'hc, 32'h6, 32'h2,
		32'he, 32'h8, 32'h4, 32'h0, 32'h9};
	always #4 core_clk = ~core_clk;
	always #6 link_clk = ~link_clk;
	sdrwb_top u_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link_clk(link_clk), .cmd_write(cmd_write),
		.cmd_read(cmd_read), .cmd_pre(cmd_pre), .cmd_group(cmd_group),
		.cmd_bank(cmd_bank), .burst_chop_select_bit(burst_chop_select_bit),
		.wdata_rise(wdata_rise), .wdata_fall(wdata_fall),
		.beat_valid(beat_valid), .beat_data(beat_data), .beat_last(beat_last),
		.rd_start(rd_start), .rd_chop(rd_chop));
	sdrwb_ctrl_model u_ctl (.link_clk(link_clk), .cmd_write(cmd_write),
		.cmd_read(cmd_read), .cmd_pre(cmd_pre), .cmd_group(cmd_group),
		.cmd_bank(cmd_bank), .burst_chop_select_bit(burst_chop_select_bit),
		.wdata_rise(wdata_rise), .wdata_fall(wdata_fall));
	// counts, verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// register port: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] d;
		rd(a, d);
		chk(d & m, e);
	endtask
	// write, then wait for the link copy to settle
	task automatic cfg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] s;
		wr(a, d);
		for (int i = 0; i < 50; i++) begin
			rd(sdrwb_pkg::OFS_STATUS, s);
			if (s[sdrwb_pkg::ST_BUSY] === 1'b0) return;
		end
		n_mismatch++;
		report_and_stop();
	endtask
	// latency, pair order and last flag of one captured burst
	task automatic mon(input int np, wl, input logic [7:0] base);
		int n;
		logic [7:0] lo;
		n = 0;
		while (n < 40 && beat_valid !== 1'b1) begin
			@(posedge link_clk);
			n++;
		end
		// count starts an edge before the command; valid shows after capture
		chk(32'(n), 32'(wl + 2));
		for (int k = 0; k < np; k++) begin
			lo = base + 8'(2 * k);
			chk({16'h0, beat_data}, {16'h0, lo + 8'h01, lo});
			chk(32'(beat_last), 32'(k == np - 1));
			@(posedge link_clk);
		end
	endtask
	task automatic lwrite(input logic [1:0] g, input logic a, input int np, wl,
		input logic [7:0] base);
		@(posedge link_clk);
		fork
			u_ctl.write(g, 2'h1, a, np, wl, base);
			mon(np, wl, base);
		join
	endtask
	// main sequence; reset spans four link edges
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			rchk(ofs_t[i], 32'hffffffff, rst_t[i]);
		end
		rchk(8'h2c, 32'hffffffff, 32'h0);
		cfg(sdrwb_pkg::OFS_CTRL, 32'h4);
		rchk(sdrwb_pkg::OFS_STATUS, 32'h4, 32'h4);
		cfg(sdrwb_pkg::OFS_CWL, 32'ha);
		rchk(sdrwb_pkg::OFS_STATUS, 32'h4, 32'h0);
		for (int i = 0; i < 5; i++) begin
			cfg(sdrwb_pkg::OFS_AL, 32'(tbl[i][5]));
			cfg(sdrwb_pkg::OFS_CTRL, 32'h4 | 32'(tbl[i][0]));
			lwrite(2'h0, tbl[i][1][0], tbl[i][2], 10 + tbl[i][5], 8'(16 * i));
			u_ctl.issue(1, 2'h2, 2'h0, tbl[i][3][0]);
			@(posedge link_clk);
			chk(32'(rd_start), 32'h1);
			chk(32'(rd_chop), 32'(tbl[i][4]));
		end
		repeat (8) @(posedge core_clk);
		// only the chopped per-command write makes its read early
		rchk(sdrwb_pkg::OFS_STATUS, 32'hff01, 32'h501);
		cfg(sdrwb_pkg::OFS_AL, 32'h0);
		for (int d = 0; d < 2; d++) for (int e = 0; e < 2; e++) begin
			cfg(sdrwb_pkg::OFS_CTRL, 32'h4 | 32'(d << 3));
			wr(sdrwb_pkg::OFS_STATUS, 32'h3);
			lwrite(2'h1, 1'b1, 4, 10, 8'h80);
			repeat ((d ? 14 : 12) - 3 + e) @(posedge link_clk);
			u_ctl.issue(2, 2'h1, 2'h1, 1'b0);
			repeat (10) @(posedge core_clk);
			rchk(sdrwb_pkg::OFS_STATUS, 32'h2, e ? 32'h0 : 32'h2);
		end
		for (int j = 0; j < 3; j++) begin
			cfg(sdrwb_pkg::OFS_AL, 32'(raw_t[j][0]));
			wr(sdrwb_pkg::OFS_STATUS, 32'h3);
			lwrite(2'h1, 1'b1, 4, 10 + raw_t[j][0], 8'hc0);
			repeat (raw_t[j][1]) @(posedge link_clk);
			u_ctl.issue(1, 2'h1, 2'h0, 1'b1);
			repeat (10) @(posedge core_clk);
			rchk(sdrwb_pkg::OFS_STATUS, 32'h1, 32'(raw_t[j][2]));
		end
		report_and_stop();
	end
	// hang guard
	initial begin
		#500000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // sdrwb_top_test
